// file: logic/tpcd_pkg.sv
// Purpose: Shared constants for the thermistor pin configuration decoder.
// Assumes: AHB-Lite register access, 32-bit data, one word per register.
// Notes:   Offsets, setting field positions and codes live here, except the option sub-fields and reserved pull-up code three.
package tpcd_pkg;
   // Register byte offsets.
   localparam logic [7:0] TPCD_OFS_THERM3  = 8'h00;
   localparam logic [7:0] TPCD_OFS_COMM    = 8'h04;
   localparam logic [7:0] TPCD_OFS_STATUS  = 8'h08;
   // Setting width and reset value.
   localparam int         TPCD_SET_W       = 8;
   localparam logic [7:0] TPCD_SET_RESET   = 8'h00;
   // Field positions inside a setting.
   localparam int         TPCD_FXN_LSB     = 0;
   localparam int         TPCD_OPT_LSB     = 2;
   // Function select codes.
   localparam logic [1:0] TPCD_FXN_ANALOG  = 2'h3;
   localparam logic [1:0] TPCD_FXN_COMM    = 2'h0;
   localparam logic [1:0] TPCD_FXN_GPO     = 2'h1;
   // Pull-up codes.
   localparam logic [1:0] TPCD_PU_18K      = 2'h0;
   localparam logic [1:0] TPCD_PU_180K     = 2'h1;
   localparam logic [1:0] TPCD_PU_NONE     = 2'h2;
   // Conversion model codes.
   localparam logic [1:0] TPCD_MDL_18K     = 2'h0;
   localparam logic [1:0] TPCD_MDL_180K    = 2'h1;
   localparam logic [1:0] TPCD_MDL_CUSTOM  = 2'h2;
   localparam logic [1:0] TPCD_MDL_RAW     = 2'h3;
   // Measurement type codes.
   localparam logic [1:0] TPCD_MT_GP       = 2'h0;
   localparam logic [1:0] TPCD_MT_CELL     = 2'h1;
   localparam logic [1:0] TPCD_MT_REPORT   = 2'h2;
   localparam logic [1:0] TPCD_MT_FET      = 2'h3;
   // AHB transfer type codes.
   localparam logic [1:0] TPCD_HTRANS_NSEQ = 2'h2;
endpackage

// file: logic/tpcd_setting_reg.sv
// Purpose: One 8-bit configuration setting held in a register.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Read data comes straight from the stored register.
`timescale 1ns/10ps
module tpcd_setting_reg (
   input  wire logic       i_clock,
   input  wire logic       i_rstn,
   input  wire logic       i_we,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_value
);
   // Stores any written byte; every value is legal.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_value <= tpcd_pkg::TPCD_SET_RESET;
      end else if (i_we) begin
         o_value <= i_wdata;
      end
   end
endmodule

// file: logic/tpcd_thermistor_pin_config_decoder.sv
// Contract
// RULE_01 - third thermistor pin setting: option and function
// RULE_02 - resets to zero, accepts any byte
// RULE_03 - function three routes to ADC, else unused
// RULE_04 - pull-up codes select 18k or 180k
// RULE_05 - pull-up code two disables all pull-ups
// RULE_06 - model bits select 18K, 180K, custom
// RULE_07 - model code three reports raw counts
// RULE_08 - type zero general input, one cell protection
// RULE_09 - type two reports only, no protection
// RULE_10 - type three feeds FET temperature protection
// RULE_11 - comm pin setting, same split, zero reset
// RULE_12 - comm function zero single-wire, one output
// RULE_13 - option bit five sets single-wire polarity
// RULE_14 - reserved or unused codes skip measurement
//
// Purpose: AHB-Lite register slave holding the pin settings and decoding them.
// Assumes: Zero-wait-state slave; always answers OKAY.
// Notes:   Decoded controls are registered one cycle after the setting changes.
//          The status word is read-only and shows both measurement enables live.
//          Reserved pull-up code three keeps the pin out of the measurement plan.
//          Bus ready and response sit in flops, so every output is registered.
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
module tpcd_thermistor_pin_config_decoder (
   input  wire logic        i_clock,
   input  wire logic        i_rstn,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic             o_therm_meas_en,
   output logic             o_therm_pu_18k,
   output logic             o_therm_pu_180k,
   output logic      [1:0]  o_therm_model,
   output logic             o_therm_raw,
   output logic             o_therm_general_input,
   output logic             o_therm_cell_prot,
   output logic             o_therm_fet_prot,
   output logic             o_therm_report_only,
   output logic             o_comm_single_wire,
   output logic             o_comm_active_low,
   output logic             o_comm_gpo,
   output logic             o_comm_meas_en
);
   // Address phase capture for the data phase write.
   logic        wr_pend_r;     // A write data phase is due.
   logic [7:0]  wr_addr_r;     // Latched write offset.
   logic [31:0] rdata_nxt;     // Read data for the next cycle.
   logic [7:0]  therm_set;     // Third thermistor pin setting.
   logic [7:0]  comm_set;      // Communication pin setting.

   // A transfer is taken on a selected NONSEQ address phase.
   wire         take     = i_hsel && i_hready && (i_htrans == tpcd_pkg::TPCD_HTRANS_NSEQ);
   wire         take_rd  = take && !i_hwrite;
   wire         take_wr  = take && i_hwrite;
   wire         we_therm = wr_pend_r && (wr_addr_r == tpcd_pkg::TPCD_OFS_THERM3); // [RULE_02]
   wire         we_comm  = wr_pend_r && (wr_addr_r == tpcd_pkg::TPCD_OFS_COMM);   // [RULE_11]

   // Field slices of each setting.
   wire [1:0]   t_fxn  = therm_set[tpcd_pkg::TPCD_FXN_LSB +: 2];   // [RULE_01]
   wire [5:0]   t_opt  = therm_set[tpcd_pkg::TPCD_OPT_LSB +: 6];   // [RULE_01]
   wire [1:0]   t_pu   = t_opt[5:4];
   wire [1:0]   t_mdl  = t_opt[3:2];
   wire [1:0]   t_mt   = t_opt[1:0];
   wire [1:0]   c_fxn  = comm_set[tpcd_pkg::TPCD_FXN_LSB +: 2];    // [RULE_11]
   wire [5:0]   c_opt  = comm_set[tpcd_pkg::TPCD_OPT_LSB +: 6];

   // Measurement only when routed and the pull-up code is not reserved.
   wire         t_routed  = (t_fxn == tpcd_pkg::TPCD_FXN_ANALOG);      // [RULE_03]
   wire         t_meas    = t_routed && (t_pu != 2'h3);                 // [RULE_14]
   wire         c_meas    = (c_fxn == tpcd_pkg::TPCD_FXN_ANALOG) && (c_opt[5:4] != 2'h3); // [RULE_14]
   wire         c_sw      = (c_fxn == tpcd_pkg::TPCD_FXN_COMM);         // [RULE_12]

   // Read mux; unmapped offsets read zero.
   wire [7:0]   rd_ofs = i_haddr[7:0];
   assign rdata_nxt = (rd_ofs == tpcd_pkg::TPCD_OFS_THERM3) ? {24'h000000, therm_set} :
                      (rd_ofs == tpcd_pkg::TPCD_OFS_COMM)   ? {24'h000000, comm_set}  :
                      (rd_ofs == tpcd_pkg::TPCD_OFS_STATUS) ? {30'h00000000, c_meas, t_meas} :
                      32'h00000000;

   // Each setting lives in its own small register module.
   // The write lands at the end of the data phase, when the write data stand.
   // Only the low byte of the write data is kept; the rest is ignored.
   // Setting storage.
   tpcd_setting_reg u_therm (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_we    (we_therm),
      .i_wdata (i_hwdata[7:0]),
      .o_value (therm_set)
   );
   tpcd_setting_reg u_comm (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_we    (we_comm),
      .i_wdata (i_hwdata[7:0]),
      .o_value (comm_set)
   );

   // The slave never inserts wait states, so ready is held high after reset.
   // Read data is captured at the address phase edge and stands all through
   // the data phase, until the next read is taken.
   // The response is always OKAY, since every byte is a legal setting.
   // Bus slave state: write pending and registered read data.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 8'h00;
         o_hrdata    <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         wr_pend_r   <= take_wr;
         wr_addr_r   <= i_haddr[7:0];
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         if (take_rd) begin
            o_hrdata <= rdata_nxt;
         end
      end
   end

   // Every control below is gated by the measurement enable, except the model.
   // This keeps an unused or reserved pin from driving a pull-up or a protection.
   // The model code is passed through so software sees what it wrote.
   // Registered decode of the third thermistor pin.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_therm_meas_en       <= 1'b0;
         o_therm_pu_18k        <= 1'b0;
         o_therm_pu_180k       <= 1'b0;
         o_therm_model         <= 2'h0;
         o_therm_raw           <= 1'b0;
         o_therm_general_input <= 1'b0;
         o_therm_cell_prot     <= 1'b0;
         o_therm_fet_prot      <= 1'b0;
         o_therm_report_only   <= 1'b0;
      end else begin
         o_therm_meas_en       <= t_meas;                                              // [RULE_03]
         o_therm_pu_18k        <= t_meas && (t_pu == tpcd_pkg::TPCD_PU_18K);           // [RULE_04]
         o_therm_pu_180k       <= t_meas && (t_pu == tpcd_pkg::TPCD_PU_180K);          // [RULE_04] [RULE_05]
         o_therm_model         <= t_mdl;                                               // [RULE_06]
         o_therm_raw           <= t_meas && (t_mdl == tpcd_pkg::TPCD_MDL_RAW);         // [RULE_07]
         o_therm_general_input <= t_meas && (t_mt == tpcd_pkg::TPCD_MT_GP);            // [RULE_08]
         o_therm_cell_prot     <= t_meas && (t_mt == tpcd_pkg::TPCD_MT_CELL);          // [RULE_08]
         o_therm_report_only   <= t_meas && (t_mt == tpcd_pkg::TPCD_MT_REPORT);        // [RULE_09]
         o_therm_fet_prot      <= t_meas && (t_mt == tpcd_pkg::TPCD_MT_FET);           // [RULE_10]
      end
   end

   // Polarity only means something in single-wire mode; output mode ignores it.
   // The other option meanings of this pin are left to the pin driver.
   // Registered decode of the communication pin.
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_comm_single_wire <= 1'b0;
         o_comm_active_low  <= 1'b0;
         o_comm_gpo         <= 1'b0;
         o_comm_meas_en     <= 1'b0;
      end else begin
         o_comm_single_wire <= c_sw;                                      // [RULE_12]
         o_comm_active_low  <= c_sw && c_opt[5];                          // [RULE_13]
         o_comm_gpo         <= (c_fxn == tpcd_pkg::TPCD_FXN_GPO);         // [RULE_12]
         o_comm_meas_en     <= c_meas;                                    // [RULE_14]
      end
   end

   // Checks on decode timing and write path.
   sequence wr_therm_s;
      take_wr && (i_haddr[7:0] == tpcd_pkg::TPCD_OFS_THERM3);
   endsequence
   therm_write_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_02]
      wr_therm_s |=> ##1 (therm_set == $past(i_hwdata[7:0])))
      else $error("Thermistor setting did not take written byte.");
   comm_write_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_11]
      (take_wr && (i_haddr[7:0] == tpcd_pkg::TPCD_OFS_COMM)) |=> ##1 (comm_set == $past(i_hwdata[7:0])))
      else $error("Comm setting did not take written byte.");
   unused_fxn_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_03]
      (therm_set[1:0] != 2'h3) |=> !o_therm_meas_en)
      else $error("Measurement enabled on unused function.");
   pullup_none_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_05]
      (therm_set[7:6] == 2'h2) |=> !(o_therm_pu_18k || o_therm_pu_180k))
      else $error("Pull-up enabled with no-pull-up code.");
   pullup_sel_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_04]
      (therm_set == 8'h03) |=> (o_therm_pu_18k && !o_therm_pu_180k))
      else $error("18k pull-up not selected.");
   raw_model_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_07]
      (therm_set[1:0] == 2'h3 && therm_set[5:4] == 2'h3 && therm_set[7:6] != 2'h3) |=> o_therm_raw)
      else $error("Raw count mode not reported.");
   model_sel_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_06]
      $changed(therm_set) |=> (o_therm_model == therm_set[5:4]))
      else $error("Model select mismatch.");
   cell_prot_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_08]
      (therm_set == 8'h07) |=> (o_therm_cell_prot && !o_therm_fet_prot))
      else $error("Cell protection not fed.");
   report_only_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_09]
      o_therm_report_only |-> !(o_therm_cell_prot || o_therm_fet_prot))
      else $error("Report-only reading fed a protection.");
   fet_prot_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_10]
      (therm_set == 8'h0F) |=> o_therm_fet_prot)
      else $error("FET protection not fed.");
   polarity_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_13]
      (comm_set[1:0] == 2'h1) |=> (o_comm_gpo && !o_comm_active_low))
      else $error("Polarity affected output mode.");
   skip_meas_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_14]
      (therm_set[7:6] == 2'h3) |=> !o_therm_meas_en)
      else $error("Reserved pull-up code was measured.");

   // Named steps of a register read: the address phase that is taken.
   sequence rd_therm_s;
      take_rd && (i_haddr[7:0] == tpcd_pkg::TPCD_OFS_THERM3);
   endsequence

   sequence rd_comm_s;
      take_rd && (i_haddr[7:0] == tpcd_pkg::TPCD_OFS_COMM);
   endsequence

   sequence rd_stat_s;
      take_rd && (i_haddr[7:0] == tpcd_pkg::TPCD_OFS_STATUS);
   endsequence

   // The bus is never stalled and never answers with an error.
   bus_okay_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_02]
      o_hreadyout && !o_hresp)
      else $error("Slave stalled or answered with an error.");

   // A read of the thermistor setting returns the stored byte.
   read_therm_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_02]
      rd_therm_s |=> (o_hrdata == {24'h000000, $past(therm_set)}))
      else $error("Thermistor setting read back wrong.");

   // A read of the communication setting returns the stored byte.
   read_comm_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_11]
      rd_comm_s |=> (o_hrdata == {24'h000000, $past(comm_set)}))
      else $error("Comm setting read back wrong.");

   // The status word shows whether each pin is scheduled for measurement.
   read_status_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_14]
      rd_stat_s |=> (o_hrdata == {30'h00000000,
                                  $past(comm_set[1:0] == 2'h3 && comm_set[7:6] != 2'h3),
                                  $past(therm_set[1:0] == 2'h3 && therm_set[7:6] != 2'h3)}))
      else $error("Status word read back wrong.");

   // Without a write strobe the thermistor setting holds.
   therm_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_02]
      !we_therm |=> $stable(therm_set))
      else $error("Thermistor setting changed without a write.");

   // Without a write strobe the communication setting holds.
   comm_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_11]
      !we_comm |=> $stable(comm_set))
      else $error("Comm setting changed without a write.");

   // The 180k pull-up code selects that pull-up alone.
   pu_180k_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_04]
      (therm_set == 8'h43) |=> (o_therm_pu_180k && !o_therm_pu_18k))
      else $error("180k pull-up not selected.");

   // The model output always follows the model bits of the setting.
   model_follow_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_06]
      1'b1 |=> (o_therm_model == $past(therm_set[5:4])))
      else $error("Model output does not follow the setting.");

   // Any model other than raw keeps the raw count flag off.
   no_raw_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_07]
      (therm_set[5:4] != 2'h3) |=> !o_therm_raw)
      else $error("Raw count flagged with a polynomial model.");

   // A routed pin with a legal pull-up code is measured.
   meas_on_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_03]
      (therm_set[1:0] == 2'h3 && therm_set[7:6] != 2'h3) |=> o_therm_meas_en)
      else $error("Routed pin not measured.");

   // General analog input with no pull-up: type zero and both pull-ups off.
   gp_input_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_08]
      (therm_set == 8'h83) |=> (o_therm_general_input && !o_therm_pu_18k && !o_therm_pu_180k))
      else $error("General analog input not decoded.");

   // Only the cell type feeds the cell protections.
   cell_only_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_08]
      (therm_set[3:2] != 2'h1) |=> !o_therm_cell_prot)
      else $error("Cell protection fed by another type.");

   // Report-only type is flagged and feeds no protection.
   report_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_09]
      (therm_set == 8'h0B) |=> (o_therm_report_only && !o_therm_cell_prot && !o_therm_fet_prot))
      else $error("Report-only type not decoded.");

   // Only the FET type feeds the FET protection.
   fet_only_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_10]
      (therm_set[3:2] != 2'h3) |=> !o_therm_fet_prot)
      else $error("FET protection fed by another type.");

   // An unused function drives no pull-up and no protection.
   unused_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_14]
      (therm_set[1:0] != 2'h3) |=> !(o_therm_pu_18k || o_therm_pu_180k || o_therm_cell_prot || o_therm_fet_prot))
      else $error("Unused pin drives a measurement control.");

   // Function zero selects single-wire mode and not output mode.
   comm_sw_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_12]
      (comm_set[1:0] == 2'h0) |=> (o_comm_single_wire && !o_comm_gpo))
      else $error("Single-wire mode not selected.");

   // Function one selects output mode and not single-wire mode.
   comm_gpo_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_12]
      (comm_set[1:0] == 2'h1) |=> (o_comm_gpo && !o_comm_single_wire))
      else $error("Output mode not selected.");

   // In single-wire mode the polarity follows option bit five.
   comm_low_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_13]
      (comm_set[1:0] == 2'h0) |=> (o_comm_active_low == $past(comm_set[7])))
      else $error("Single-wire polarity wrong.");

   // The communication pin is measured only when routed with a legal pull-up.
   comm_skip_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_14]
      (comm_set[1:0] != 2'h3 || comm_set[7:6] == 2'h3) |=> !o_comm_meas_en)
      else $error("Comm pin measured while not routed.");

   // A routed communication pin with a legal pull-up is measured.
   comm_meas_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE_14]
      (comm_set[1:0] == 2'h3 && comm_set[7:6] != 2'h3) |=> o_comm_meas_en)
      else $error("Routed comm pin not measured.");
endmodule

// file: test/tpcd_tb.sv
// Purpose: Self-checking bench for the thermistor pin configuration decoder.
// Assumes: Zero-wait AHB-Lite slave with the settings and the status word at the package offsets.
// Notes:   Every byte value goes into both settings, and each decode is compared with the field meanings.
`timescale 1ns/10ps
module tb;
   logic        i_clock = 1'b0;   // System clock, 100 MHz.
   logic        i_rstn  = 1'b0;   // Active-low reset, held at start.
   logic        hsel    = 1'b0;   // Slave select driven by the bench master.
   logic [31:0] haddr   = 32'h0;  // Byte address of the transfer.
   logic [1:0]  htrans  = 2'h0;   // Transfer type, IDLE when quiet.
   logic        hwrite  = 1'b0;   // Direction of the transfer.
   logic [2:0]  hsize   = 3'h2;   // Always a whole word.
   logic [31:0] hwdata  = 32'h0;  // Write data of the data phase.
   logic [31:0] hrdata;           // Read data from the slave.
   logic        hreadyout;        // Slave ready, which is also the bus ready.
   logic        hresp;            // Slave response.
   logic        t_en, t_18, t_180, t_raw, t_gen, t_cell, t_fet, t_rep;  // Thermistor decode outputs.
   logic [1:0]  t_mdl;            // Conversion model output.
   logic        c_sw, c_al, c_gpo, c_en;  // Communication pin decode outputs.
   int          miscompares = 0;  // Count of failed comparisons.
   int          n_tests     = 0;  // Count of comparisons made.
   int          cycles      = 0;  // Clock cycles since start, for the hang limit.

   // The device under test, with the bus ready looped back from the slave.
   tpcd_thermistor_pin_config_decoder u_tpcd_thermistor_pin_config_decoder (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .o_therm_meas_en(t_en), .o_therm_pu_18k(t_18),
      .o_therm_pu_180k(t_180), .o_therm_model(t_mdl), .o_therm_raw(t_raw), .o_therm_general_input(t_gen),
      .o_therm_cell_prot(t_cell), .o_therm_fet_prot(t_fet), .o_therm_report_only(t_rep),
      .o_comm_single_wire(c_sw), .o_comm_active_low(c_al), .o_comm_gpo(c_gpo), .o_comm_meas_en(c_en));

   // The clock turns over every half period of 5 ns.
   always #5 i_clock = ~i_clock;

   // Compares one value and reports a mismatch at once.
   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests++;
         if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task conclude;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask

   // Waits for a rising edge at which ready is high; only the bench timeout ends a wait that never does.
   task wait_ready;
      begin
         do begin
            @(posedge i_clock);
         end while (hreadyout !== 1'b1);
         check({31'h0, hreadyout}, 32'h1);
      end
   endtask

   // One single AHB-Lite transfer: address phase, then data phase, read data taken at its end.
   task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      begin
         hsel   <= 1'b1;
         haddr  <= a;
         htrans <= tpcd_pkg::TPCD_HTRANS_NSEQ;
         hwrite <= wr;
         wait_ready();
         htrans <= 2'h0;
         hwdata <= wd;
         wait_ready();
         rd = hrdata;
         check({31'h0, hresp}, 32'h0);
      end
   endtask

   // Cuts a hang short and counts it as a mismatch.
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   // Main sequence: reset values, every byte in both settings, unmapped access, reset in mid-run.
   initial begin
      logic [31:0] rd;
      logic [7:0]  v;
      logic        en, cen;
      repeat (8) @(posedge i_clock);
      i_rstn <= 1'b1;
      @(posedge i_clock);
      xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_THERM3}, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_COMM}, 32'h0, rd);
      check(rd, 32'h0);
      check({28'h0, c_sw, c_al, c_gpo, c_en}, 32'h8);
      check({22'h0, t_en, t_18, t_180, t_mdl, t_raw, t_gen, t_cell, t_rep, t_fet}, 32'h0);
      // Upper write bits are junk on purpose; only the low byte may be kept.
      for (int i = 0; i < 256; i++) begin
         v = i[7:0];
         en  = (v[1:0] == 2'h3) && (v[7:6] != 2'h3);
         cen = (v[1:0] == 2'h3) && (v[7:6] != 2'h3);
         xfer(1'b1, {24'h0, tpcd_pkg::TPCD_OFS_THERM3}, {24'hA5C3E1, v}, rd);
         xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_THERM3}, 32'h0, rd);
         check(rd, {24'h0, v});
         xfer(1'b1, {24'h0, tpcd_pkg::TPCD_OFS_COMM}, {24'h5A3C1E, v}, rd);
         xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_COMM}, 32'h0, rd);
         check(rd, {24'h0, v});
         xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_STATUS}, 32'h0, rd);
         check(rd, {30'h0, cen, en});
         check({22'h0, t_en, t_18, t_180, t_mdl, t_raw, t_gen, t_cell, t_rep, t_fet},
               {22'h0, en, en && v[7:6] == 2'h0, en && v[7:6] == 2'h1, v[5:4], en && v[5:4] == 2'h3,
                en && v[3:2] == 2'h0, en && v[3:2] == 2'h1, en && v[3:2] == 2'h2, en && v[3:2] == 2'h3});
         check({28'h0, c_sw, c_al, c_gpo, c_en},
               {28'h0, v[1:0] == 2'h0, v[1:0] == 2'h0 && v[7], v[1:0] == 2'h1, cen});
      end
      // An unmapped place reads zero and a write there leaves the thermistor setting alone.
      xfer(1'b1, 32'h0000000C, 32'h000000FF, rd);
      xfer(1'b0, 32'h0000000C, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_THERM3}, 32'h0, rd);
      check(rd, 32'hFF);
      // A reset in mid-run returns both settings to zero.
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rstn <= 1'b1;
      @(posedge i_clock);
      xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_THERM3}, 32'h0, rd);
      check(rd, 32'h0);
      xfer(1'b0, {24'h0, tpcd_pkg::TPCD_OFS_COMM}, 32'h0, rd);
      check(rd, 32'h0);
      check({28'h0, c_sw, c_al, c_gpo, c_en}, 32'h8);
      check({22'h0, t_en, t_18, t_180, t_mdl, t_raw, t_gen, t_cell, t_rep, t_fet}, 32'h0);
      conclude();
   end
endmodule
